// file: design/pcs_phy_regs.sv
// Purpose: line layer configuration, control status and negotiation fault status
// Assumes: host strobes and line events arrive from pins, synchronised here
// Notes:   host reaches registers over the byte port; read data is registered
`timescale 1ns/1ps
module pcs_phy_regs #(
  parameter int STARTUP_CYCLES = pcs_pkg::STARTUP_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // host byte port
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  // events from the analog line section
  input  wire logic       link_fail_evt,
  input  wire logic       link_good_evt,
  input  wire logic       jabber_evt,
  input  wire logic       rx_pol_inverted,
  input  wire logic       partner_full_duplex,
  input  wire logic       partner_remote_fault,
  input  wire logic       neg_done_evt,
  input  wire logic [7:0] neg_fail_cause,
  // controls to the analog line section
  output logic            squelch_on,
  output logic            jabber_guard_on,
  output logic            adv_remote_fault,
  output logic            adv_pause,
  output logic            rx_invert,
  output logic            tx_active,
  output logic            rx_active,
  output logic            loopback_on,
  output logic            full_duplex,
  output logic            neg_running,
  output logic            line_ready
);
  // ****************************************
  // input synchronisation
  // ****************************************
  localparam int NSYNC = 33;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  assign raw_in = {host_wr, host_rd, link_fail_evt, link_good_evt, jabber_evt,
                   rx_pol_inverted, partner_full_duplex, partner_remote_fault,
                   neg_done_evt, neg_fail_cause, host_addr, host_wdata};

  pcs_sync2 #(.W(NSYNC)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .d       (raw_in),
    .q       (syn)
  );

  logic       s_wr;
  logic       s_rd;
  logic       s_lfail;
  logic       s_lgood;
  logic       s_jab;
  logic       s_polinv;
  logic       s_pfd;
  logic       s_prf;
  logic       s_ndone;
  logic [7:0] s_cause;
  logic [7:0] s_addr;
  logic [7:0] s_wdata;
  assign s_wr     = syn[32];
  assign s_rd     = syn[31];
  assign s_lfail  = syn[30];
  assign s_lgood  = syn[29];
  assign s_jab    = syn[28];
  assign s_polinv = syn[27];
  assign s_pfd    = syn[26];
  assign s_prf    = syn[25];
  assign s_ndone  = syn[24];
  assign s_cause  = syn[23:16];
  // address and data share the strobe's delay; host must settle them first
  assign s_addr   = syn[15:8];
  assign s_wdata  = syn[7:0];

  logic wr_p;
  logic rd_p;
  pcs_host_port u_port (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .wr_lvl   (s_wr),
    .rd_lvl   (s_rd),
    .wr_pulse (wr_p),
    .rd_pulse (rd_p)
  );

  logic wr_cfg;
  logic wr_ctl;
  assign wr_cfg = wr_p && (s_addr == pcs_pkg::PCS_ADDR_CONFIG);
  assign wr_ctl = wr_p && (s_addr == pcs_pkg::PCS_ADDR_CONTROL);

  // ****************************************
  // configuration register
  // ****************************************
  logic [7:0] cfg_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cfg_q <= pcs_pkg::PCS_CONFIG_RESET;
    else if (clk_en && wr_cfg)
      cfg_q <= s_wdata;
  end

  logic neg_en;
  assign neg_en = cfg_q[pcs_pkg::CF_NEG];

  // ****************************************
  // control register
  // ****************************************
  logic [7:3] ctl_rw_q;
  logic       link_q;
  logic       polarity_reversed_flag_q;
  logic       prf_q;
  logic [7:0] ctl_q;
  logic       enables_all;
  logic       enables_all_q;
  assign ctl_q       = {ctl_rw_q, prf_q, polarity_reversed_flag_q, link_q};
  assign enables_all = ctl_q[pcs_pkg::CN_LINE_EN] & ctl_q[pcs_pkg::CN_TX_EN]
                     & ctl_q[pcs_pkg::CN_RX_EN];

  pcs_pkg::pcs_neg_state_t neg_q;
  logic neg_start;
  logic neg_ev_done;
  logic neg_ev_fail;
  assign neg_start   = neg_en && enables_all && !enables_all_q;
  assign neg_ev_done = (neg_q == pcs_pkg::PCS_NEG_RUN) && s_ndone;
  assign neg_ev_fail = (neg_q == pcs_pkg::PCS_NEG_RUN) && (s_cause != 8'h00);

  // hardware events win over a host write in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ctl_rw_q <= pcs_pkg::PCS_CONTROL_RESET[7:3];
    else if (clk_en)
    begin
      if (wr_ctl)
      begin
        ctl_rw_q[7:5] <= s_wdata[7:5];
        ctl_rw_q[pcs_pkg::CN_LOOP] <= s_wdata[pcs_pkg::CN_LOOP];
        if (!neg_en)
          ctl_rw_q[pcs_pkg::CN_DUPLEX] <= s_wdata[pcs_pkg::CN_DUPLEX];
      end
      // supervision drops transmitter and receiver on link failure
      if (cfg_q[pcs_pkg::CF_LINKSUP] && s_lfail)
      begin
        ctl_rw_q[pcs_pkg::CN_TX_EN] <= 1'b0;
        ctl_rw_q[pcs_pkg::CN_RX_EN] <= 1'b0;
      end
      if (cfg_q[pcs_pkg::CF_JABBER] && s_jab)
        ctl_rw_q[pcs_pkg::CN_LOOP] <= 1'b0;
      if (neg_en && neg_ev_done)
        ctl_rw_q[pcs_pkg::CN_DUPLEX] <= s_pfd;
      if (neg_en && neg_ev_fail)
        ctl_rw_q[pcs_pkg::CN_DUPLEX] <= 1'b0;
    end
  end

  // link flag: supervision decides; disabled supervision reports good
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      link_q   <= pcs_pkg::PCS_CONTROL_RESET[pcs_pkg::CN_LINK];
      polarity_reversed_flag_q <= pcs_pkg::PCS_CONTROL_RESET[pcs_pkg::CN_POLARITY_REVERSED_FLAG];
      prf_q    <= pcs_pkg::PCS_CONTROL_RESET[pcs_pkg::CN_PARTNER_RF];
    end
    else if (clk_en)
    begin
      if (!cfg_q[pcs_pkg::CF_LINKSUP])
        link_q <= 1'b1;
      else if (s_lfail)
        link_q <= 1'b0;
      else if (s_lgood)
        link_q <= 1'b1;
      polarity_reversed_flag_q <= cfg_q[pcs_pkg::CF_AUTO_POLARITY_ENABLE] & s_polinv;
      prf_q    <= s_prf;
    end
  end

  // ****************************************
  // negotiation tracking
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      neg_q         <= pcs_pkg::PCS_NEG_IDLE;
      enables_all_q <= 1'b0;
    end
    else if (clk_en)
    begin
      enables_all_q <= enables_all;
      case (neg_q)
        pcs_pkg::PCS_NEG_IDLE:
          if (neg_start)
            neg_q <= pcs_pkg::PCS_NEG_RUN;
        pcs_pkg::PCS_NEG_RUN:
          if (!neg_en || !enables_all)
            neg_q <= pcs_pkg::PCS_NEG_IDLE;
          else if (neg_ev_fail)
            neg_q <= pcs_pkg::PCS_NEG_FAIL;
          else if (s_ndone)
            neg_q <= pcs_pkg::PCS_NEG_DONE;
        pcs_pkg::PCS_NEG_DONE,
        pcs_pkg::PCS_NEG_FAIL:
          if (!enables_all || !neg_en)
            neg_q <= pcs_pkg::PCS_NEG_IDLE;
        default:
          neg_q <= pcs_pkg::PCS_NEG_IDLE;
      endcase
    end
  end

  // ****************************************
  // negotiation fault status
  // ****************************************
  // held until a new attempt; host writes never reach it
  logic [7:0] sta_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sta_q <= pcs_pkg::PCS_STATUS_RESET;
    else if (clk_en)
    begin
      if (neg_ev_fail)
        sta_q <= s_cause;
      else if (neg_start)
        sta_q <= pcs_pkg::PCS_STATUS_RESET;
    end
  end

  // ****************************************
  // startup timer
  // ****************************************
  localparam int TW = $clog2(STARTUP_CYCLES + 1);
  logic [TW-1:0] start_cnt_q;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      start_cnt_q <= '0;
    else if (clk_en)
    begin
      if (!ctl_q[pcs_pkg::CN_LINE_EN])
        start_cnt_q <= '0;
      else if (start_cnt_q != TW'(STARTUP_CYCLES))
        start_cnt_q <= start_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // outputs and read data
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      squelch_on       <= 1'b0;
      jabber_guard_on  <= 1'b0;
      adv_remote_fault <= 1'b0;
      adv_pause        <= 1'b0;
      rx_invert        <= 1'b0;
      tx_active        <= 1'b0;
      rx_active        <= 1'b0;
      loopback_on      <= 1'b0;
      full_duplex      <= 1'b0;
      neg_running      <= 1'b0;
      line_ready       <= 1'b0;
    end
    else if (clk_en)
    begin
      squelch_on       <= cfg_q[pcs_pkg::CF_SQUELCH];
      jabber_guard_on  <= cfg_q[pcs_pkg::CF_JABBER];
      adv_remote_fault <= cfg_q[pcs_pkg::CF_ADV_RF];
      adv_pause        <= cfg_q[pcs_pkg::CF_ADV_PAUSE];
      // auto polarity overrides the manual bit
      rx_invert        <= cfg_q[pcs_pkg::CF_AUTO_POLARITY_ENABLE] ? s_polinv
                                                     : cfg_q[pcs_pkg::CF_MANUAL_POLARITY_REVERSE];
      tx_active        <= ctl_q[pcs_pkg::CN_LINE_EN] & ctl_q[pcs_pkg::CN_TX_EN];
      rx_active        <= ctl_q[pcs_pkg::CN_LINE_EN] & ctl_q[pcs_pkg::CN_RX_EN];
      loopback_on      <= ctl_q[pcs_pkg::CN_LOOP];
      full_duplex      <= ctl_q[pcs_pkg::CN_DUPLEX];
      neg_running      <= (neg_q == pcs_pkg::PCS_NEG_RUN);
      line_ready       <= ctl_q[pcs_pkg::CN_LINE_EN] && (start_cnt_q == TW'(STARTUP_CYCLES));
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      host_rdata <= 8'h00;
    else if (clk_en && rd_p)
    begin
      case (s_addr)
        pcs_pkg::PCS_ADDR_CONFIG:  host_rdata <= cfg_q;
        pcs_pkg::PCS_ADDR_CONTROL: host_rdata <= ctl_q;
        pcs_pkg::PCS_ADDR_STATUS:  host_rdata <= sta_q;
        default:                   host_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_loop_jabber: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && cfg_q[pcs_pkg::CF_JABBER] && s_jab) |=> !ctl_q[pcs_pkg::CN_LOOP])
    else $error("loopback survived jabber");
  a_link_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && cfg_q[pcs_pkg::CF_LINKSUP] && s_lfail) |=>
      (!ctl_q[pcs_pkg::CN_TX_EN] && !ctl_q[pcs_pkg::CN_RX_EN] && !ctl_q[pcs_pkg::CN_LINK]))
    else $error("link failure did not disable line");
  a_fail_half: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && neg_en && neg_ev_fail) |=> (!ctl_q[pcs_pkg::CN_DUPLEX] && sta_q == $past(s_cause)))
    else $error("failure not recorded");
  a_status_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (!neg_ev_fail && !neg_start) |=> $stable(sta_q))
    else $error("status changed without cause");
  a_pol_manual: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && cfg_q[pcs_pkg::CF_AUTO_POLARITY_ENABLE]) |=> (rx_invert == $past(s_polinv)))
    else $error("manual polarity leaked");
  a_duplex_lock: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ctl && neg_en && !neg_ev_done && !neg_ev_fail) |=> $stable(ctl_q[pcs_pkg::CN_DUPLEX]))
    else $error("duplex written under negotiation");
  a_cfg_write: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_cfg) |=> (cfg_q == $past(s_wdata)))
    else $error("configuration write lost");
  a_squelch_out: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && wr_cfg) |=> ##1 (!clk_en || squelch_on == $past(s_wdata[7], 2)))
    else $error("squelch output wrong");
endmodule

// file: design/pcs_pkg.sv
// Purpose: constants for the line layer configuration and negotiation status bank
// Assumes: byte wide register port, one clock, asynchronous high reset
// Notes:   offsets are byte addresses on the host register port
//
// Operation
// - configuration bit 7 turns smart squelch qualification on or off
// - bit 6 enables link supervision; link failure disables transmitter, receiver, updates flag
// - bit 5 enables jabber protection; cleared means no protection at all
// - with jabber protection on, detected jabber clears loopback
// - bit 4 enables auto-negotiation
// - bit 3 advertises remote fault detection during negotiation
// - bit 2 advertises pause capability during negotiation
// - bit 1 enables automatic receive polarity detection and correction
// - bit 0 manually reverses receive polarity
// - manual reversal ignored while automatic polarity correction is enabled
// - status bit 7 flags good-check failure from incompatible link
// - status bit 6 flags good-check failure from line status fault
// - status bits 5 and 2 flag missing fast link pulses, ack and ability
// - status bit 4 flags ack-detect failure from word with ack clear
// - status bit 3 flags ack-detect failure from inconsistent words
// - status bit 1 flags ability-detect failure from words with ack set
// - status bit 0 flags ability-detect failure, no three matching words
// - on negotiation failure record cause and fall back to half duplex
// - duplex select is read-only while negotiation is enabled
// - with auto polarity, report detected reversal in control status bit
package pcs_pkg;
  localparam logic [7:0] PCS_ADDR_CONTROL = 8'h78;
  localparam logic [7:0] PCS_ADDR_CONFIG  = 8'h79;
  localparam logic [7:0] PCS_ADDR_STATUS  = 8'h80;
  localparam logic [7:0] PCS_CONFIG_RESET = 8'h00;
  localparam logic [7:0] PCS_STATUS_RESET = 8'h00;
  localparam logic [7:0] PCS_CONTROL_RESET = 8'h00;
  // configuration fields
  localparam int CF_SQUELCH  = 7;
  localparam int CF_LINKSUP  = 6;
  localparam int CF_JABBER   = 5;
  localparam int CF_NEG      = 4;
  localparam int CF_ADV_RF   = 3;
  localparam int CF_ADV_PAUSE = 2;
  localparam int CF_AUTO_POLARITY_ENABLE  = 1;
  localparam int CF_MANUAL_POLARITY_REVERSE   = 0;
  // control fields
  localparam int CN_LINE_EN  = 7;
  localparam int CN_TX_EN    = 6;
  localparam int CN_RX_EN    = 5;
  localparam int CN_DUPLEX   = 4;
  localparam int CN_LOOP     = 3;
  localparam int CN_PARTNER_RF = 2;
  localparam int CN_POLARITY_REVERSED_FLAG   = 1;
  localparam int CN_LINK     = 0;
  // status fields
  localparam int ST_GC_INCOMPAT = 7;
  localparam int ST_GC_LINE     = 6;
  localparam int ST_ACK_PULSE   = 5;
  localparam int ST_ACK_MISMATCH = 4;
  localparam int ST_ACK_CONSIST = 3;
  localparam int ST_ABL_PULSE   = 2;
  localparam int ST_ABL_ACK     = 1;
  localparam int ST_ABL_MATCH   = 0;
  // startup time of the line layer
  localparam int STARTUP_US     = 1000;
  localparam int CLK_MHZ        = 125;
  localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
  typedef enum logic [1:0] {
    PCS_NEG_IDLE = 2'b00,
    PCS_NEG_RUN  = 2'b01,
    PCS_NEG_DONE = 2'b10,
    PCS_NEG_FAIL = 2'b11
  } pcs_neg_state_t;
endpackage

// file: design/pcs_sync2.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: input asynchronous to sys_clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
module pcs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: design/pcs_host_port.sv
// Purpose: byte register port write/read strobe capture
// Assumes: strobes synchronised already, active high, same clock
// Notes:   one access pulse per strobe assertion
`timescale 1ns/1ps
module pcs_host_port (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic wr_lvl,
  input  wire logic rd_lvl,
  output logic      wr_pulse,
  output logic      rd_pulse
);
  logic wr_prev_q;
  logic rd_prev_q;

  // rising edge detection: one access per strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_prev_q <= wr_lvl;
      rd_prev_q <= rd_lvl;
    end
  end

  assign wr_pulse = clk_en & wr_lvl & ~wr_prev_q;
  assign rd_pulse = clk_en & rd_lvl & ~rd_prev_q;
endmodule

// file: testbench/pcs_line_partner.sv
// Purpose: behavioural remote partner and line section event source
// Assumes: one command per go pulse, taken at a rising edge
// Notes:   an event stands four cycles after a lag of 0..15 cycles
`timescale 1ns/1ps
module pcs_line_partner (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [2:0] cmd,
  input  wire logic       go,
  input  wire logic [3:0] lag,
  input  wire logic [7:0] cause,
  output logic            link_fail_evt,
  output logic            link_good_evt,
  output logic            jabber_evt,
  output logic            neg_done_evt,
  output logic      [7:0] neg_fail_cause
);
  logic [4:0] cnt_q;
  logic [2:0] cmd_q;
  logic [7:0] cause_q;
  logic       act;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q   <= 5'h00;
      cmd_q   <= 3'h0;
      cause_q <= 8'h00;
    end
    else if (go)
    begin
      cnt_q   <= {1'b0, lag} + 5'h04;
      cmd_q   <= cmd;
      cause_q <= cause;
    end
    else if (cnt_q != 5'h00)
    begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  // long enough to survive the two-flop synchroniser
  assign act            = (cnt_q != 5'h00) && (cnt_q <= 5'h04);
  assign link_fail_evt  = act && (cmd_q == 3'h1);
  assign link_good_evt  = act && (cmd_q == 3'h2);
  assign jabber_evt     = act && (cmd_q == 3'h3);
  assign neg_done_evt   = act && (cmd_q == 3'h4);
  assign neg_fail_cause = (act && (cmd_q == 3'h5)) ? cause_q : 8'h00;
endmodule

// file: testbench/phy_config_and_negotiation_enable_status_tb_top.sv
// Purpose: self-checking bench for the line layer register bank
// Assumes: host write strobes held five cycles, read strobes six, low four cycles between accesses
// Notes:   reads are checked by a monitor against a queue of expected bytes
`timescale 1ns/1ps
module phy_config_and_negotiation_enable_status_tb_top;
  logic       sys_clk, rst, clk_en, host_wr, host_rd, rx_pol_inverted;
  logic       partner_full_duplex, partner_remote_fault, p_go;
  logic [7:0] host_addr, host_wdata, host_rdata, p_cause, neg_fail_cause;
  logic [2:0] p_cmd;
  logic [3:0] p_lag;
  logic       link_fail_evt, link_good_evt, jabber_evt, neg_done_evt;
  logic       squelch_on, jabber_guard_on, adv_remote_fault, adv_pause, rx_invert;
  logic       tx_active, rx_active, loopback_on, full_duplex, neg_running, line_ready;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  cfg;
  int          fails, total_checks;
  event        rd_ev;

  pcs_phy_regs #(.STARTUP_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .link_fail_evt(link_fail_evt), .link_good_evt(link_good_evt),
    .jabber_evt(jabber_evt), .rx_pol_inverted(rx_pol_inverted),
    .partner_full_duplex(partner_full_duplex), .partner_remote_fault(partner_remote_fault),
    .neg_done_evt(neg_done_evt), .neg_fail_cause(neg_fail_cause), .squelch_on(squelch_on),
    .jabber_guard_on(jabber_guard_on), .adv_remote_fault(adv_remote_fault),
    .adv_pause(adv_pause), .rx_invert(rx_invert), .tx_active(tx_active),
    .rx_active(rx_active), .loopback_on(loopback_on), .full_duplex(full_duplex),
    .neg_running(neg_running), .line_ready(line_ready));

  pcs_line_partner partner_u (.sys_clk(sys_clk), .rst(rst), .cmd(p_cmd), .go(p_go),
    .lag(p_lag), .cause(p_cause), .link_fail_evt(link_fail_evt),
    .link_good_evt(link_good_evt), .jabber_evt(jabber_evt), .neg_done_evt(neg_done_evt),
    .neg_fail_cause(neg_fail_cause));

  // ****************
  // tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic host_wr8(input logic [7:0] a, input logic [7:0] d);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    cyc(5);
    host_wr <= 1'b0;
    cyc(4);
  endtask

  task automatic host_rd8(input logic [7:0] a, input logic [7:0] e);
    host_addr <= a;
    host_rd   <= 1'b1;
    cyc(5);
    exp_q.push_back(e);
    @(negedge sys_clk);
    -> rd_ev;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    cyc(4);
  endtask

  // random lag exercises both prompt and slow answers
  task automatic fire(input logic [2:0] c, input logic [7:0] k);
    seed = xs(seed);
    p_cmd   <= c;
    p_cause <= k;
    p_lag   <= seed[3:0];
    p_go    <= 1'b1;
    cyc(1);
    p_go <= 1'b0;
    cyc(26);
  endtask

  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t read got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_out(input logic e, input logic g, input string n);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %0t output %s got %b want %b", $time, n, g, e);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************
  // clock, monitor, watchdog
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  forever
  begin
    @(rd_ev);
    chk_rd(exp_q.pop_front(), host_rdata);
  end

  // whole sequence needs well under 5000 cycles
  initial
  begin
    #200000;
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim();
  end

  // ****************
  // tests
  // ****************
  initial
  begin
    seed = 32'h0000000f;
    {rst, clk_en, host_wr, host_rd, p_go, rx_pol_inverted} = 6'b110000;
    {partner_full_duplex, partner_remote_fault} = 2'b00;
    {host_addr, host_wdata, p_cause, p_cmd, p_lag} = '0;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    host_rd8(8'h78, 8'h01);
    host_rd8(8'h79, 8'h00);
    host_rd8(8'h80, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      cfg = seed[7:0];
      rx_pol_inverted <= seed[8];
      host_wr8(8'h79, cfg);
      host_rd8(8'h79, cfg);
      host_rd8(8'h78, {6'h00, cfg[1] & seed[8], 1'b1});
      @(negedge sys_clk);
      chk_out(cfg[7], squelch_on, "squelch");
      chk_out(cfg[5], jabber_guard_on, "jabber");
      chk_out(cfg[3], adv_remote_fault, "adv_rf");
      chk_out(cfg[2], adv_pause, "adv_pause");
      chk_out(cfg[1] ? seed[8] : cfg[0], rx_invert, "rx_invert");
      @(posedge sys_clk);
    end
    // a write made while the clock enable is low must be lost
    clk_en <= 1'b0;
    host_wr8(8'h79, ~cfg);
    clk_en <= 1'b1;
    host_rd8(8'h79, cfg);
    host_wr8(8'h80, 8'hff);
    host_rd8(8'h80, 8'h00);
    host_wr8(8'h55, 8'hff);
    host_rd8(8'h55, 8'h00);
    $display("test config done");
    host_wr8(8'h79, 8'h00);
    host_wr8(8'h79, 8'h10); // negotiation before enables
    for (int i = 0; i < 8; i++)
    begin
      host_wr8(8'h78, 8'ha0);
      host_wr8(8'h78, 8'he0);
      host_rd8(8'h80, 8'h00);
      fire(3'h5, 8'h01 << i);
      cyc(10);
      host_rd8(8'h80, 8'h01 << i);
      @(negedge sys_clk);
      chk_out(1'b0, full_duplex, "full_duplex");
      @(posedge sys_clk);
    end
    host_wr8(8'h78, 8'ha0);
    partner_full_duplex <= 1'b1;
    host_wr8(8'h78, 8'he0);
    @(negedge sys_clk);
    chk_out(1'b1, neg_running, "neg_running");
    @(posedge sys_clk);
    fire(3'h4, 8'h00);
    host_wr8(8'h78, 8'he0);
    @(negedge sys_clk);
    chk_out(1'b1, full_duplex, "full_duplex");
    chk_out(1'b0, neg_running, "neg_running");
    @(posedge sys_clk);
    host_wr8(8'h78, 8'ha0);
    host_wr8(8'h78, 8'he0); // restart by toggling an enable
    fire(3'h5, 8'h81);
    host_rd8(8'h80, 8'h81);
    @(negedge sys_clk);
    chk_out(1'b0, full_duplex, "full_duplex");
    @(posedge sys_clk);
    $display("test negotiation done");
    host_wr8(8'h79, 8'h40);
    host_wr8(8'h78, 8'he0);
    @(negedge sys_clk);
    chk_out(1'b1, tx_active, "tx_active");
    @(posedge sys_clk);
    fire(3'h1, 8'h00);
    @(negedge sys_clk);
    chk_out(1'b0, tx_active, "tx_active");
    chk_out(1'b0, rx_active, "rx_active");
    @(posedge sys_clk);
    host_rd8(8'h78, 8'h80);
    fire(3'h2, 8'h00);
    host_rd8(8'h78, 8'h81);
    $display("test link done");
    for (int j = 0; j < 2; j++)
    begin
      host_wr8(8'h79, j == 0 ? 8'h20 : 8'h00);
      host_wr8(8'h78, 8'h88);
      fire(3'h3, 8'h00);
      @(negedge sys_clk);
      chk_out(j == 1, loopback_on, "loopback");
      chk_out(1'b1, line_ready, "line_ready");
      @(posedge sys_clk);
    end
    $display("test jabber done");
    end_sim();
  end
endmodule
